/* dv/ppst_meas_src.sv */
`timescale 1ns/1ns
// stand-in for measurement processing: pushes catalogue words one at a time
module ppst_meas_src (
  // clock
  input  wire logic                       i_mclk,
  // catalogue write side
  output logic                            o_wr_en,
  output logic [ppst_pkg::SRC_W-1:0]      o_wr_addr,
  output logic [ppst_pkg::VAL_W-1:0]      o_wr_data
);
  initial
  begin
    o_wr_en   = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 32'h00000000;
  end

  // idle gives a slow source; lines are inverted when idle so stale words never look valid
  task automatic put(input logic [7:0] addr, input logic [31:0] data, input int idle = 0);
    repeat (idle) @(negedge i_mclk);
    @(negedge i_mclk);
    o_wr_en   = 1'b1;
    o_wr_addr = addr;
    o_wr_data = data;
    @(negedge i_mclk);
    o_wr_en   = 1'b0;
    o_wr_addr = ~addr;
    o_wr_data = ~data;
  endtask
endmodule

/* dv/ppst_stages_sva.sv */
`timescale 1ns/1ns
// sweep timing and per-stage status relations seen at the ports
module ppst_stages_chk #(
  parameter int NUM_STAGES  = ppst_pkg::MAX_STAGES,
  parameter int TICK_CYCLES = ppst_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_rst_n,
  // configuration
  input  wire logic                i_func_active,
  input  wire logic [1:0]          i_setting_group,
  // results
  input  ppst_pkg::ppst_status_t   o_status [NUM_STAGES],
  input  wire logic                o_cycle_done
);
  int unsigned gap;
  logic        seen;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // cycles since the last sweep end; the first sweep has nothing to compare with
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      gap  <= 0;
      seen <= 1'b0;
    end
    else
    begin
      gap  <= o_cycle_done ? 0 : gap + 1;
      seen <= seen | o_cycle_done;
    end
  end

  a_done_single: assert property (o_cycle_done |=> !o_cycle_done)
    else $error("sweep done pulse longer than one cycle");
  a_sweep_period: assert property (seen && o_cycle_done |-> gap == TICK_CYCLES - 1)
    else $error("sweep spacing wrong");
  a_sweep_alive: assert property (seen |-> gap < TICK_CYCLES)
    else $error("evaluation stopped");

  // per-stage status relations
  for (genvar s = 0; s < NUM_STAGES; s++)
  begin : g_st
    a_cond_at_sweep: assert property ($changed(o_status[s].cond) |-> o_cycle_done)
      else $error("condition changed outside a sweep");
    a_trip_is_cond: assert property (o_status[s].trip == (o_status[s].cond == ppst_pkg::PPST_TRIP))
      else $error("trip flag and condition disagree");
    a_off_timing: assert property (o_status[s].cond == ppst_pkg::PPST_DISABLED |->
      o_status[s].op_time == 0 && o_status[s].remaining == 0)
      else $error("disabled stage shows timing");
    a_hidden_off: assert property (o_cycle_done && (!o_status[s].visible || !i_func_active)
      |-> o_status[s].cond == ppst_pkg::PPST_DISABLED)
      else $error("inactive stage not disabled");
    a_start_remain: assert property (o_status[s].cond == ppst_pkg::PPST_START |->
      o_status[s].remaining != 0 && o_status[s].remaining <= o_status[s].op_time)
      else $error("remaining time out of range");
    a_count_down: assert property (o_cycle_done && o_status[s].cond == ppst_pkg::PPST_START
      && $past(o_status[s].cond) == ppst_pkg::PPST_START && $stable(o_status[s].op_time)
      |-> o_status[s].remaining == $past(o_status[s].remaining) - 1)
      else $error("timer did not advance by one cycle");
    a_direct_trip: assert property (o_cycle_done && o_status[s].cond == ppst_pkg::PPST_TRIP
      && $past(o_status[s].cond) inside {ppst_pkg::PPST_NORMAL, ppst_pkg::PPST_DISABLED}
      |-> o_status[s].op_time == 0)
      else $error("trip without running the delay");
  end

  c_group_sweep: cover property (o_cycle_done && i_setting_group != 2'h0);
  c_start: cover property (o_status[0].cond == ppst_pkg::PPST_START);
  c_trip: cover property ($rose(o_status[0].trip));
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ns
// self-checking bench for the programmable stage bank
module tb_top;
  localparam int NS   = 4;
  localparam int TICK = 40;
  localparam int BAND = (100 * int'(ppst_pkg::HYST_DEFAULT)) >> ppst_pkg::HYST_FRAC;

  logic                       i_mclk;
  logic                       i_rst_n;
  logic                       wr_en;
  logic [ppst_pkg::SRC_W-1:0] wr_addr;
  logic [ppst_pkg::VAL_W-1:0] wr_data;
  logic                       func_active;
  logic [ppst_pkg::CNT_W-1:0] stage_count;
  logic [1:0]                 group;
  ppst_pkg::ppst_stage_cfg_t  cfg [ppst_pkg::NUM_GROUPS][NS];
  ppst_pkg::ppst_status_t     status [NS];
  logic [ppst_pkg::VAL_W-1:0] scaled [NS][ppst_pkg::MAX_CH];
  logic                       cycle_done;
  int                         mismatches;
  int                         cmp_count;

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  ppst_meas_src meas (.i_mclk(i_mclk), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data));

  ppst_stages #(.NUM_STAGES(NS), .TICK_CYCLES(TICK)) dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_meas_wr_en(wr_en), .i_meas_wr_addr(wr_addr),
    .i_meas_wr_data(wr_data), .i_func_active(func_active), .i_stage_count(stage_count),
    .i_setting_group(group), .i_cfg(cfg), .o_status(status), .o_scaled(scaled),
    .o_cycle_done(cycle_done));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic cond(input int s, input ppst_pkg::ppst_cond_t c);
    chk(32'(status[s].cond), 32'(c));
  endtask

  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // bounded wait for the sweep end, then settle to the falling edge
  task automatic sweep();
    int n;
    for (n = 0; n < 2 * TICK; n++)
    begin
      @(posedge i_mclk);
      if (cycle_done === 1'b1)
        break;
    end
    if (n == 2 * TICK)
    begin
      mismatches++;
      end_sim();
    end
    @(negedge i_mclk);
  endtask

  task automatic stage(input int g, s, nch, dly, input ppst_pkg::ppst_comb_t comb);
    cfg[g][s].enable = 1'b1;
    cfg[g][s].comb   = comb;
    cfg[g][s].nch    = 2'(nch);
    cfg[g][s].delay  = 19'(dly);
  endtask

  task automatic chan(input int g, s, k, src, input ppst_pkg::ppst_mode_t m, input int lvl,
                      input logic [31:0] mult);
    cfg[g][s].ch[k] = '{src: 8'(src), mode: m, level: 32'(lvl), mult: mult,
                        hyst: ppst_pkg::HYST_DEFAULT};
  endtask

  // four stages: over, under with gain 2, all-of pair, rate of change
  task automatic setup();
    for (int a = 0; a < 5; a++)
      meas.put(8'(a), 32'h00000000, a % 2);
    for (int g = 0; g < 2; g++)
    begin
      stage(g, 0, 1, 3, ppst_pkg::PPST_ANY);
      chan(g, 0, 0, 0, ppst_pkg::PPST_OVER, g ? 1000 : 100, ppst_pkg::MULT_UNITY);
      stage(g, 1, 1, 0, ppst_pkg::PPST_ANY);
      chan(g, 1, 0, 1, ppst_pkg::PPST_UNDER, 100, 32'h00020000);
      stage(g, 2, 2, 0, ppst_pkg::PPST_ALL);
      chan(g, 2, 0, 3, ppst_pkg::PPST_OVER, 10, ppst_pkg::MULT_UNITY);
      chan(g, 2, 1, 4, ppst_pkg::PPST_OVER, 10, ppst_pkg::MULT_UNITY);
      stage(g, 3, 1, 0, ppst_pkg::PPST_ANY);
      chan(g, 3, 0, 2, ppst_pkg::PPST_ROC, 50, ppst_pkg::MULT_UNITY);
    end
    func_active = 1'b1;
    stage_count = 4'h4;
    sweep();
  endtask

  task automatic t_over();
    meas.put(8'h00, 32'd100);
    sweep();
    cond(0, ppst_pkg::PPST_NORMAL);
    chk(32'(status[0].op_time), 32'd3);
    meas.put(8'h00, 32'd101);
    sweep();
    cond(0, ppst_pkg::PPST_START);
    chk(32'(status[0].start), 32'd1);
    chk(32'(status[0].remaining), 32'd2);
    sweep();
    chk(32'(status[0].remaining), 32'd1);
    sweep();
    cond(0, ppst_pkg::PPST_TRIP);
    chk(32'(status[0].trip), 32'd1);
    meas.put(8'h00, 32'(101 - BAND));
    sweep();
    cond(0, ppst_pkg::PPST_TRIP);
    meas.put(8'h00, 32'(100 - BAND));
    sweep();
    cond(0, ppst_pkg::PPST_NORMAL);
    $display("test over done");
  endtask

  task automatic t_under();
    meas.put(8'h01, 32'd60);
    sweep();
    chk(scaled[1][0], (32'd60 * 32'h00020000) >> ppst_pkg::MULT_FRAC);
    cond(1, ppst_pkg::PPST_NORMAL);
    meas.put(8'h01, 32'd40);
    sweep();
    cond(1, ppst_pkg::PPST_TRIP);
    $display("test under done");
  endtask

  task automatic t_all_roc();
    meas.put(8'h03, 32'd20);
    sweep();
    cond(2, ppst_pkg::PPST_NORMAL);
    meas.put(8'h04, 32'd20);
    sweep();
    cond(2, ppst_pkg::PPST_TRIP);
    meas.put(8'h02, 32'd100);
    sweep();
    cond(3, ppst_pkg::PPST_TRIP);
    sweep();
    cond(3, ppst_pkg::PPST_NORMAL);
    meas.put(8'h02, 32'd0);
    sweep();
    cond(3, ppst_pkg::PPST_TRIP);
    $display("test combine and rate done");
  endtask

  task automatic t_group();
    meas.put(8'h00, 32'd500);
    sweep();
    cond(0, ppst_pkg::PPST_START);
    group = 2'h1;
    sweep();
    cond(0, ppst_pkg::PPST_NORMAL);
    group = 2'h0;
    sweep();
    chk(32'(status[0].remaining), 32'd2);
    $display("test group done");
  endtask

  // one word from six of the catalogue regions, seen through the scaled outputs;
  // the first sweep may catch a half-written set, so judge the second
  task automatic t_cat();
    cfg[0][1].ch[1]     = cfg[0][1].ch[0];
    cfg[0][1].ch[1].src = 8'(ppst_pkg::PHASE_CURRENT_SEL_BASE + 13);
    cfg[0][0].ch[0].src = 8'(ppst_pkg::ZERO_SEQ_CURRENT_BASE);
    cfg[0][1].ch[0].src = 8'(ppst_pkg::CALC_RESIDUAL_VOLTAGE_IDX);
    cfg[0][2].ch[0].src = 8'(ppst_pkg::THREE_PHASE_APPARENT_POWER);
    cfg[0][2].ch[1].src = 8'(ppst_pkg::SEQ_IMPEDANCE_ANGLE_IDX);
    cfg[0][3].ch[0].src = 8'(ppst_pkg::SCALED_CURVE_OUTPUT_BASE);
    meas.put(8'(ppst_pkg::PHASE_CURRENT_SEL_BASE + 13), 32'd4);
    meas.put(8'(ppst_pkg::ZERO_SEQ_CURRENT_BASE), 32'd7);
    meas.put(8'(ppst_pkg::CALC_RESIDUAL_VOLTAGE_IDX), 32'd5);
    meas.put(8'(ppst_pkg::THREE_PHASE_APPARENT_POWER), 32'd8);
    meas.put(8'(ppst_pkg::SEQ_IMPEDANCE_ANGLE_IDX), 32'd6);
    meas.put(8'(ppst_pkg::SCALED_CURVE_OUTPUT_BASE), 32'd9);
    sweep();
    sweep();
    chk(scaled[1][1], 32'd8);
    chk(scaled[0][0], 32'd7);
    chk(scaled[1][0], 32'd10);
    chk(scaled[2][0], 32'd8);
    chk(scaled[2][1], 32'd6);
    chk(scaled[3][0], 32'd9);
    $display("test catalogue done");
  endtask

  task automatic t_count();
    stage_count = 4'h1;
    sweep();
    chk(32'(status[1].visible), 32'd0);
    cond(1, ppst_pkg::PPST_DISABLED);
    chk(32'(status[1].op_time), 32'd0);
    stage_count = 4'h0;
    sweep();
    chk(32'(status[0].visible), 32'd1);
    stage_count = 4'h6;
    sweep();
    chk(32'(status[3].visible), 32'd1);
    cfg[0][1].enable = 1'b0;
    sweep();
    cond(1, ppst_pkg::PPST_DISABLED);
    func_active = 1'b0;
    sweep();
    cond(0, ppst_pkg::PPST_DISABLED);
    $display("test count done");
  endtask

  initial
  begin
    mismatches  = 0;
    cmp_count   = 0;
    i_rst_n     = 1'b0;
    func_active = 1'b0;
    stage_count = 4'h0;
    group       = 2'h0;
    foreach (cfg[g, s])
      cfg[g][s] = '0;
    repeat (6) @(negedge i_mclk);
    i_rst_n = 1'b1;
    for (int s = 0; s < NS; s++)
      cond(s, ppst_pkg::PPST_DISABLED);
    chk(32'(cycle_done), 32'd0);
    $display("test reset done");
    setup();
    t_over();
    t_under();
    t_all_roc();
    t_group();
    t_cat();
    t_count();
    end_sim();
  end
endmodule

bind ppst_stages ppst_stages_chk #(.NUM_STAGES(NUM_STAGES), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_func_active(i_func_active),
  .i_setting_group(i_setting_group), .o_status(o_status), .o_cycle_done(o_cycle_done));

/* rtl/ppst_meas_ram.sv */
`timescale 1ns/1ns
// catalogue store: one write port, registered read
module ppst_meas_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 256,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic             i_mclk,
  // write side
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_addr,
  input  wire logic [WIDTH-1:0] i_wr_data,
  // read side
  input  wire logic [AW-1:0]    i_rd_addr,
  output logic      [WIDTH-1:0] o_rd_data
);

  // elaboration check: the address must reach every word
  if (DEPTH < 2 || (1 << AW) < DEPTH)
    $error("ppst_meas_ram: bad depth");

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on storage: unwritten words are undefined until first update
  always_ff @(posedge i_mclk)
  begin
    if (i_wr_en)
      mem[i_wr_addr] <= i_wr_data;
    o_rd_data <= mem[i_rd_addr];
  end

endmodule

/* rtl/ppst_stages.sv */
`timescale 1ns/1ns
// How it works
// - ten independent comparison stages, each trip usable alone or by user logic
// - each stage watches one to three selected catalogue measurements
// - per signal the pick-up term is over level, under level or rate of change
// - after pick-up a definite-time delay runs; trip asserts when it expires
// - all comparisons and timers are evaluated once per 5 ms cycle
// - pick-up uses the latest stored sample, so latency follows source refresh
// - with the function activated, a count setting gives 1 to 10 stages
// - stages beyond the count stay hidden and inactive
// - a counted stage also needs its own enable setting to operate
// - an enabled stage reports condition, expected operating time, time remaining
// - an inactive stage reports only the disabled condition, timing zero
// - setting group switch changes parameters live without stopping evaluation
// - catalogue holds per-phase and residual current RMS, harmonics, TRMS, angle
// - catalogue holds sequence currents and resistive/capacitive residual parts
// - catalogue holds line, phase, residual and sequence voltages with angles
// - catalogue holds three-phase and phase S, P, Q and direction quantities
// - catalogue holds loop and sequence R, X, Z and G, B, Y values
// - catalogue holds frequencies, thermal, sensors, mA inputs, scaled curves
// - each measurement is scaled by a multiplier and the result is readable
// - release uses hysteresis relative to pick-up level, default three percent
// - over mode picks up only when the scaled signal is strictly above level
module ppst_stages #(
  parameter int NUM_STAGES  = ppst_pkg::MAX_STAGES,
  parameter int TICK_CYCLES = ppst_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst_n,
  // catalogue updates from measurement processing
  input  wire logic                      i_meas_wr_en,
  input  wire logic [ppst_pkg::SRC_W-1:0] i_meas_wr_addr,
  input  wire logic [ppst_pkg::VAL_W-1:0] i_meas_wr_data,
  // function configuration
  input  wire logic                      i_func_active,
  input  wire logic [ppst_pkg::CNT_W-1:0] i_stage_count,
  input  wire logic [1:0]                i_setting_group,
  input  ppst_pkg::ppst_stage_cfg_t      i_cfg [ppst_pkg::NUM_GROUPS][NUM_STAGES],
  // stage results
  output ppst_pkg::ppst_status_t         o_status [NUM_STAGES],
  output logic [ppst_pkg::VAL_W-1:0]     o_scaled [NUM_STAGES][ppst_pkg::MAX_CH],
  output logic                           o_cycle_done
);

  localparam int VW  = ppst_pkg::VAL_W;
  localparam int MC  = ppst_pkg::MAX_CH;
  localparam int DW  = ppst_pkg::DLY_W;
  localparam int TW  = $clog2(TICK_CYCLES);
  localparam int SIW = (NUM_STAGES > 1) ? $clog2(NUM_STAGES) : 1; // a single stage still needs a bit
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // elaboration checks: the whole sweep must fit inside one tick period
  if (NUM_STAGES < 1 || NUM_STAGES > ppst_pkg::MAX_STAGES)
    $error("ppst_stages: NUM_STAGES must be 1..10");
  if (TICK_CYCLES < 2 * NUM_STAGES * MC + 4)
    $error("ppst_stages: TICK_CYCLES too short for one sweep");

  // scaled value: signed product, back to Q0 by dropping the fraction
  function automatic logic [VW-1:0] scale(input logic [VW-1:0] v, input logic [VW-1:0] m);
    logic signed [2*VW-1:0] p;
    p = $signed(v) * $signed(m);
    return p[ppst_pkg::MULT_FRAC +: VW];
  endfunction

  function automatic logic [VW-1:0] absval(input logic [VW-1:0] v);
    return v[VW-1] ? (~v + 32'h00000001) : v;
  endfunction

  // hysteresis band as a fraction of the magnitude of the level
  function automatic logic [VW-1:0] band(input logic [VW-1:0] lvl,
                                         input logic [ppst_pkg::HYST_W-1:0] h);
    logic [VW+ppst_pkg::HYST_W-1:0] p;
    p = absval(lvl) * h;
    return p[ppst_pkg::HYST_FRAC +: VW];
  endfunction

  // clamp of the count setting into 1..NUM_STAGES
  function automatic logic [ppst_pkg::CNT_W-1:0] eff_count(input logic [ppst_pkg::CNT_W-1:0] c);
    if (c == 4'h0)
      return 4'h1;
    if (32'(c) > NUM_STAGES)
      return ppst_pkg::CNT_W'(NUM_STAGES);
    return c;
  endfunction

  // 5 ms processing tick from the divider
  logic [TW-1:0] tick_cnt;
  logic [TW-1:0] next_tick_cnt;
  logic          tick;
  logic          next_tick;

  always_comb
  begin
    next_tick     = 1'b0;
    next_tick_cnt = tick_cnt + 1'b1;
    if (tick_cnt == TICK_LAST)
    begin
      next_tick_cnt = '0;
      next_tick     = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  // sweep sequencer: read one channel's source, evaluate it, move on
  typedef enum logic [1:0] {SQ_IDLE, SQ_READ, SQ_EVAL, SQ_TIMER} ppst_seq_t;

  ppst_seq_t              seq;
  ppst_seq_t              next_seq;
  logic [SIW-1:0]         seq_stage;
  logic [SIW-1:0]         next_seq_stage;
  logic [1:0]             seq_ch;
  logic [1:0]             next_seq_ch;
  logic [MC-1:0]          pick [NUM_STAGES];
  logic [MC-1:0]          next_pick [NUM_STAGES];
  logic [VW-1:0]          prev [NUM_STAGES][MC];
  logic [VW-1:0]          next_prev [NUM_STAGES][MC];
  logic [VW-1:0]          scaled [NUM_STAGES][MC];
  logic [VW-1:0]          next_scaled [NUM_STAGES][MC];
  logic [VW-1:0]          rd_data;
  logic [ppst_pkg::SRC_W-1:0] rd_addr;
  logic [NUM_STAGES-1:0]  active;

  ppst_pkg::ppst_stage_cfg_t cfg [NUM_STAGES];
  ppst_pkg::ppst_chan_cfg_t  cur;

  // live group selection; takes effect at the next evaluated channel
  always_comb
  begin
    for (int s = 0; s < NUM_STAGES; s++)
    begin
      cfg[s]    = i_cfg[i_setting_group][s];
      active[s] = i_func_active && (s < 32'(eff_count(i_stage_count)))
                  && cfg[s].enable;
    end
    cur     = cfg[seq_stage].ch[seq_ch];
    rd_addr = cur.src;
  end

  // the catalogue: measured quantities live at the package's fixed indices
  ppst_meas_ram #(
    .WIDTH (VW),
    .DEPTH (ppst_pkg::CAT_DEPTH)
  ) u_cat (
    .i_mclk    (i_mclk),
    .i_wr_en   (i_meas_wr_en),
    .i_wr_addr (i_meas_wr_addr),
    .i_wr_data (i_meas_wr_data),
    .i_rd_addr (rd_addr),
    .o_rd_data (rd_data)
  );

  // channel evaluation; the held pick state gives the release hysteresis
  always_comb
  begin
    logic [VW-1:0] meas;
    logic [VW-1:0] x;
    logic [VW-1:0] dlt;
    logic [VW-1:0] hb;
    logic          on_cond;
    logic          hold_cond;
    logic          used;
    meas           = '0;
    x              = '0;
    dlt            = '0;
    hb             = '0;
    on_cond        = 1'b0;
    hold_cond      = 1'b0;
    used           = 1'b0;
    next_seq       = seq;
    next_seq_stage = seq_stage;
    next_seq_ch    = seq_ch;
    next_pick      = pick;
    next_prev      = prev;
    next_scaled    = scaled;
    case (seq)
      SQ_IDLE:
      begin
        if (tick)
        begin
          next_seq       = SQ_READ;
          next_seq_stage = '0;
          next_seq_ch    = 2'h0;
        end
      end
      SQ_READ:
        next_seq = SQ_EVAL;
      SQ_EVAL:
      begin
        // out-of-catalogue selector reads as zero
        meas = (32'(cur.src) < ppst_pkg::CAT_SIZE) ? rd_data : '0;
        x    = scale(meas, cur.mult);
        dlt  = x - prev[seq_stage][seq_ch];
        hb   = band(cur.level, cur.hyst);
        used = active[seq_stage] && (seq_ch < cfg[seq_stage].nch);
        case (cur.mode)
          ppst_pkg::PPST_OVER:
          begin
            on_cond   = $signed(x) > $signed(cur.level);
            hold_cond = $signed(x) > $signed(cur.level - hb);
          end
          ppst_pkg::PPST_UNDER:
          begin
            on_cond   = $signed(x) < $signed(cur.level);
            hold_cond = $signed(x) < $signed(cur.level + hb);
          end
          ppst_pkg::PPST_ROC:
          begin
            on_cond   = absval(dlt) > absval(cur.level);
            hold_cond = absval(dlt) > (absval(cur.level) - hb);
          end
          default:
          begin
            on_cond   = 1'b0;
            hold_cond = 1'b0;
          end
        endcase
        // latest stored sample is used, so pick-up lags its source's refresh
        next_pick[seq_stage][seq_ch]   = used && (pick[seq_stage][seq_ch] ?
                                                  hold_cond : on_cond);
        next_prev[seq_stage][seq_ch]   = x;
        next_scaled[seq_stage][seq_ch] = x;
        if (seq_ch == 2'(MC - 1))
        begin
          next_seq_ch = 2'h0;
          if (seq_stage == SIW'(NUM_STAGES - 1))
            next_seq = SQ_TIMER;
          else
          begin
            next_seq_stage = seq_stage + 1'b1;
            next_seq       = SQ_READ;
          end
        end
        else
        begin
          next_seq_ch = seq_ch + 1'b1;
          next_seq    = SQ_READ;
        end
      end
      SQ_TIMER:
        next_seq = SQ_IDLE;
      default:
        next_seq = SQ_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seq       <= SQ_IDLE;
      seq_stage <= '0;
      seq_ch    <= 2'h0;
      pick      <= '{default: '0};
      prev      <= '{default: '0};
      scaled    <= '{default: '0};
    end
    else
    begin
      seq       <= next_seq;
      seq_stage <= next_seq_stage;
      seq_ch    <= next_seq_ch;
      pick      <= next_pick;
      prev      <= next_prev;
      scaled    <= next_scaled;
    end
  end

  // stage timers and reported state, updated once at the end of a sweep; the visible flag follows the settings every cycle
  logic [DW-1:0]          tmr [NUM_STAGES];
  logic [DW-1:0]          next_tmr [NUM_STAGES];
  ppst_pkg::ppst_status_t status [NUM_STAGES];
  ppst_pkg::ppst_status_t next_status [NUM_STAGES];
  logic                   done;
  logic                   next_done;

  always_comb
  begin
    logic [MC-1:0] mask;
    logic          pu;
    logic [DW-1:0] t;
    mask        = '0;
    pu          = 1'b0;
    t           = '0;
    next_tmr    = tmr;
    next_status = status;
    next_done   = (seq == SQ_TIMER);
    for (int s = 0; s < NUM_STAGES; s++)
    begin
      next_status[s].visible = i_func_active
                               && (s < 32'(eff_count(i_stage_count)));
      if (seq == SQ_TIMER)
      begin
        for (int c = 0; c < MC; c++)
          mask[c] = (c < 32'(cfg[s].nch));
        if (cfg[s].comb == ppst_pkg::PPST_ALL)
          pu = (|mask) && (&(pick[s] | ~mask));
        else
          pu = |(pick[s] & mask);
        if (!active[s])
        begin
          next_tmr[s]              = '0;
          next_status[s].cond      = ppst_pkg::PPST_DISABLED;
          next_status[s].start     = 1'b0;
          next_status[s].trip      = 1'b0;
          next_status[s].op_time   = '0;
          next_status[s].remaining = '0;
        end
        else
        begin
          // saturating count of 5 ms cycles; drop-out clears it
          t = pu ? ((tmr[s] >= cfg[s].delay) ? tmr[s] : tmr[s] + 1'b1) : '0;
          next_tmr[s]              = t;
          next_status[s].start     = pu;
          next_status[s].trip      = pu && (t >= cfg[s].delay);
          next_status[s].op_time   = cfg[s].delay;
          next_status[s].remaining = (pu && t < cfg[s].delay) ?
                                     (cfg[s].delay - t) : '0;
          if (pu && t >= cfg[s].delay)
            next_status[s].cond = ppst_pkg::PPST_TRIP;
          else if (pu)
            next_status[s].cond = ppst_pkg::PPST_START;
          else
            next_status[s].cond = ppst_pkg::PPST_NORMAL;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      done <= 1'b0;
      for (int s = 0; s < NUM_STAGES; s++)
      begin
        tmr[s]    <= '0;
        status[s] <= '{cond: ppst_pkg::PPST_DISABLED, default: '0};
      end
    end
    else
    begin
      done   <= next_done;
      tmr    <= next_tmr;
      status <= next_status;
    end
  end

  // outputs straight from the registers above
  assign o_cycle_done = done;
  assign o_status     = status;
  assign o_scaled     = scaled;

endmodule

/* shared/ppst_pkg.sv */
package ppst_pkg;

  // bank geometry
  localparam int MAX_STAGES = 10;
  localparam int MAX_CH     = 3;
  localparam int NUM_GROUPS = 4;
  localparam int VAL_W      = 32;
  localparam int SRC_W      = 8;
  localparam int DLY_W      = 19;
  localparam int CNT_W      = 4;

  // fixed-point formats: multiplier Q16.16, hysteresis as fraction of 2^20
  localparam int MULT_FRAC = 16;
  localparam int HYST_W    = 20;
  localparam int HYST_FRAC = 20;
  localparam logic [HYST_W-1:0] HYST_DEFAULT = 20'h07AE1;
  localparam logic [VAL_W-1:0]  MULT_UNITY   = 32'h00010000;

  // processing cycle timing
  localparam int CYCLE_TIME_US = 5000;
  localparam int CLK_HZ        = 250_000_000;
  localparam int TICK_CYCLES   = (CLK_HZ / 1_000_000) * CYCLE_TIME_US;

  // measurement catalogue layout, one word per quantity
  localparam int CAT_DEPTH                  = 256;
  localparam int PHASE_CURRENT_SEL_BASE     = 0;
  localparam int ZERO_SEQ_CURRENT_BASE      = 70;
  localparam int VOLTAGE_BASE               = 85;
  localparam int CALC_RESIDUAL_VOLTAGE_IDX  = 98;
  localparam int THREE_PHASE_APPARENT_POWER = 104;
  localparam int LOOP_IMPEDANCE_BASE        = 124;
  localparam int SEQ_IMPEDANCE_BASE         = 166;
  localparam int SEQ_IMPEDANCE_ANGLE_IDX    = 172;
  localparam int ADMITTANCE_BASE            = 173;
  localparam int RESIDUAL_ADMITTANCE_BASE   = 194;
  localparam int FREQUENCY_BASE             = 201;
  localparam int THERMAL_BASE               = 204;
  localparam int TEMP_SENSOR_BASE           = 207;
  localparam int MA_INPUT_BASE              = 231;
  localparam int SCALED_CURVE_OUTPUT_BASE   = 235;
  localparam int CAT_SIZE                   = 239;

  typedef enum logic [1:0] {PPST_OVER, PPST_UNDER, PPST_ROC} ppst_mode_t;
  typedef enum logic [1:0] {PPST_DISABLED, PPST_NORMAL, PPST_START, PPST_TRIP} ppst_cond_t;
  typedef enum logic {PPST_ANY, PPST_ALL} ppst_comb_t;

  typedef struct packed {
    logic [SRC_W-1:0]  src;
    ppst_mode_t        mode;
    logic [VAL_W-1:0]  level;
    logic [VAL_W-1:0]  mult;
    logic [HYST_W-1:0] hyst;
  } ppst_chan_cfg_t;

  typedef struct packed {
    logic                         enable;
    ppst_comb_t                   comb;
    logic [1:0]                   nch;
    logic [DLY_W-1:0]             delay;
    ppst_chan_cfg_t [MAX_CH-1:0]  ch;
  } ppst_stage_cfg_t;

  typedef struct packed {
    ppst_cond_t       cond;
    logic             visible;
    logic             start;
    logic             trip;
    logic [DLY_W-1:0] op_time;
    logic [DLY_W-1:0] remaining;
  } ppst_status_t;

endpackage
